// File: logic/cmla_map.svh
/*
 * Constants of the eight-cell output macrocell array: register offsets,
 * field positions, reset values and pin-to-cell numbering.
 * Assumes a 32-bit plain register port, byte offsets, one word per register.
 */
// Overview of operation
// [RL1] Permit 0, emulate 1, select 1: combinatorial I/O
// [RL2] Registered-device combinatorial I/O feeds back own pin
// [RL3] Permit 1, emulate 0, select 1: input only
// [RL4] Inputs use adjacent pin; end cells use clock/enable
// [RL5] Without registers, clock/enable pins feed end cells
// [RL6] Permit bit 1 disables every cell flip-flop
// [RL7] Pins 15, 16 combinatorial output: no feedback
// [RL8] Polarity bit 1 active high, 0 active low
// [RL9] Power-up clears every flip-flop low
// [RL10] Registered pin reads high after power-up
// [RL11] Combinatorial output follows logic after power-up
// [RL12] Preload registers from pins, any state
// [RL13] Security bit blocks configuration readback
// [RL14] Security cleared only by full erase; here reset_n also clears it
// [RL15] Sixty-four bit user signature word
// [RL16] Signature readable regardless of security
// [RL17] Programmer erases automatically before programming
// [RL18] Registered cell loads eight-term sum on clock rise
// [RL19] Registered feedback from inverted flip-flop output
// [RL20] Permit 1, emulate 0, select 0: combinatorial output
// [RL21] Non-registered I/O: seven terms, eighth enables, pin feedback
// [RL22] Static configuration; unlisted combinations unsupported
`ifndef CMLA_MAP_SVH
`define CMLA_MAP_SVH

`define CMLA_ADDR_W 8
`define CMLA_DATA_W 32
`define CMLA_CELLS 8
`define CMLA_TERMS 8

`define CMLA_OFS_GLOBAL 8'h00
`define CMLA_OFS_SELECT 8'h04
`define CMLA_OFS_POLARITY 8'h08
`define CMLA_OFS_CONTROL 8'h0c
`define CMLA_OFS_STATUS 8'h10
`define CMLA_OFS_SIG_LO 8'h14
`define CMLA_OFS_SIG_HI 8'h18

`define CMLA_GLB_PERMIT_BIT 0
`define CMLA_GLB_EMUL_BIT 1
`define CMLA_CTL_PRELOAD_BIT 0
`define CMLA_CTL_SECURE_BIT 1
`define CMLA_CTL_ERASE_BIT 2
`define CMLA_STS_SECURE_BIT 8
`define CMLA_STS_UNSUP_LSB 16

`define CMLA_RST_PERMIT 1'b0
`define CMLA_RST_EMUL 1'b0
`define CMLA_RST_BYTE 8'h00
`define CMLA_RST_SIG 64'h0000000000000000
`define CMLA_RST_WORD 32'h00000000

// Cells whose pins are 15 and 16
`define CMLA_NOFB_CELL_A 3
`define CMLA_NOFB_CELL_B 4

`endif

// File: logic/cmla_pkg.sv
/*
 * Types of the macrocell array: cell modes, the configuration word and
 * the per-cell result bundle.
 * Assumes cmla_map.svh for widths.
 */
`include "cmla_map.svh"

package cmla_pkg;

	typedef enum logic [2:0] {
		CMLA_REG_OUT,
		CMLA_COMB_IO,
		CMLA_COMB_OUT,
		CMLA_DED_IN,
		CMLA_UNSUP
	} cmla_mode_e;

	typedef struct packed {
		logic global_register_permit_bit;
		logic global_emulation_select_bit;
		logic [`CMLA_CELLS-1:0] cell_mode_select_bit;
		logic [`CMLA_CELLS-1:0] cell_polarity_bit;
	} cmla_cfg_s;

	typedef struct packed {
		logic reg_d;
		logic reg_used;
		logic drive_val;
		logic drive_en;
		logic feedback;
		logic unsup;
	} cmla_cell_s;

endpackage

// File: logic/cmla_cell.sv
/*
 * One output macrocell: mode decode, product-term sum, polarity XOR,
 * enable select and feedback select. Purely combinational; the flip-flop
 * lives in the top so every top output comes from a register.
 * Assumes the caller supplies the adjacent pin and the two shared pins.
 */
`timescale 1ns/1ps
`include "cmla_map.svh"

module cmla_cell #(
	parameter int IDX = 0
) (
	// Configuration
	input wire logic permit,
	input wire logic emul,
	input wire logic sel,
	input wire logic pol,
	// Array and pins
	input wire logic [`CMLA_TERMS-1:0] terms,
	input wire logic reg_q,
	input wire logic own_pin,
	input wire logic adj_pin,
	input wire logic clk_pin,
	input wire logic oe_pin_n,
	// Result
	output cmla_pkg::cmla_cell_s res
);

	function automatic cmla_pkg::cmla_mode_e decode(input logic p, input logic e, input logic s);
		cmla_pkg::cmla_mode_e m;
		m = cmla_pkg::CMLA_UNSUP; // see [RL22]
		if (!p && e && !s)
			m = cmla_pkg::CMLA_REG_OUT;
		else if (!p && e && s)
			m = cmla_pkg::CMLA_COMB_IO; // see [RL1]
		else if (p && !e && !s)
			m = cmla_pkg::CMLA_COMB_OUT; // see [RL20]
		else if (p && !e && s)
			m = cmla_pkg::CMLA_DED_IN; // see [RL3]
		else if (p && e && s)
			m = cmla_pkg::CMLA_COMB_IO; // see [RL21]
		return m;
	endfunction

	localparam logic END_CELL = (IDX == 0) || (IDX == `CMLA_CELLS - 1);
	localparam logic NO_FB = (IDX == `CMLA_NOFB_CELL_A) || (IDX == `CMLA_NOFB_CELL_B);

	cmla_pkg::cmla_mode_e mode;
	logic sum8;
	logic sum7;
	logic shared_pin;

	assign mode = decode(permit, emul, sel);
	assign sum8 = |terms;
	assign sum7 = |terms[`CMLA_TERMS-2:0];
	// First cell takes the enable pin, last cell the clock pin
	assign shared_pin = (IDX == 0) ? oe_pin_n : clk_pin; // see [RL4] see [RL5]

	always_comb begin
		res = '0;
		unique case (mode)
			cmla_pkg::CMLA_REG_OUT: begin
				// Stored inverted so a cleared register shows high at the pin
				res.reg_d = ~(pol ? sum8 : ~sum8); // see [RL18] see [RL8]
				res.reg_used = 1'b1;
				res.drive_val = ~reg_q; // see [RL10]
				res.drive_en = ~oe_pin_n; // see [RL18]
				res.feedback = ~reg_q; // see [RL19]
			end
			cmla_pkg::CMLA_COMB_IO: begin
				res.drive_val = pol ? sum7 : ~sum7; // see [RL8] see [RL11]
				res.drive_en = terms[`CMLA_TERMS-1]; // see [RL1] see [RL21]
				res.feedback = own_pin; // see [RL2] see [RL21]
			end
			cmla_pkg::CMLA_COMB_OUT: begin
				res.drive_val = pol ? sum8 : ~sum8; // see [RL20] see [RL11]
				res.drive_en = 1'b1;
				if (END_CELL)
					res.feedback = shared_pin; // see [RL5]
				else if (NO_FB)
					res.feedback = 1'b0; // see [RL7]
				else
					res.feedback = pol ? sum8 : ~sum8;
			end
			cmla_pkg::CMLA_DED_IN: begin
				res.drive_en = 1'b0; // see [RL3]
				res.feedback = END_CELL ? shared_pin : adj_pin; // see [RL4]
			end
			cmla_pkg::CMLA_UNSUP: begin
				res.unsup = 1'b1; // see [RL22]
			end
		endcase
	end

endmodule

// File: logic/cmla_top.sv
/*
 * Eight configurable output macrocells with their flip-flops, register
 * preload, security bit, signature word and a plain register port.
 * Assumes all pins are synchronous to clk; the shared clock pin is sampled
 * and its rising edge loads the cell registers on the clk edge that first samples it high.
 */
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/1ps
`include "cmla_map.svh"

module cmla_top (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Register port
	input wire logic [`CMLA_ADDR_W-1:0] addr,
	input wire logic [`CMLA_DATA_W-1:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [`CMLA_DATA_W-1:0] rd_data,
	// Shared pins
	input wire logic clk_pin,
	input wire logic oe_pin_n,
	// Cell I/O pins
	input wire logic [`CMLA_CELLS-1:0] io_in,
	output logic [`CMLA_CELLS-1:0] io_out,
	output logic [`CMLA_CELLS-1:0] io_oe_n,
	// AND array side
	input wire logic [`CMLA_CELLS*`CMLA_TERMS-1:0] product_terms,
	output logic [`CMLA_CELLS-1:0] array_feedback
);

	cmla_pkg::cmla_cfg_s cfg_q;
	logic secure_q;
	logic [63:0] signature_q;
	logic [`CMLA_CELLS-1:0] cell_q;
	logic [`CMLA_CELLS-1:0] cell_d;
	logic clk_pin_q;
	logic [`CMLA_CELLS-1:0] io_out_q;
	logic [`CMLA_CELLS-1:0] io_oe_n_q;
	logic [`CMLA_CELLS-1:0] feedback_q;
	logic [`CMLA_DATA_W-1:0] rd_data_q;
	logic [`CMLA_DATA_W-1:0] rd_data_d;
	logic [`CMLA_CELLS-1:0] unsup;
	logic [`CMLA_CELLS-1:0] reg_used;
	logic [`CMLA_CELLS-1:0] drive_val;
	logic [`CMLA_CELLS-1:0] drive_en;
	logic [`CMLA_CELLS-1:0] fb;
	logic [`CMLA_CELLS-1:0] reg_d;
	logic clk_rise;
	logic wr_global;
	logic wr_select;
	logic wr_polarity;
	logic wr_control;
	logic wr_sig_lo;
	logic wr_sig_hi;
	logic do_erase;
	logic do_preload;

	function automatic logic hit(input logic [`CMLA_ADDR_W-1:0] a,
		input logic [`CMLA_ADDR_W-1:0] ofs);
		return a == ofs;
	endfunction

	assign wr_global = wr_en && hit(addr, `CMLA_OFS_GLOBAL);
	assign wr_select = wr_en && hit(addr, `CMLA_OFS_SELECT);
	assign wr_polarity = wr_en && hit(addr, `CMLA_OFS_POLARITY);
	assign wr_control = wr_en && hit(addr, `CMLA_OFS_CONTROL);
	assign wr_sig_lo = wr_en && hit(addr, `CMLA_OFS_SIG_LO);
	assign wr_sig_hi = wr_en && hit(addr, `CMLA_OFS_SIG_HI);
	assign do_erase = wr_control && wr_data[`CMLA_CTL_ERASE_BIT];
	assign do_preload = wr_control && wr_data[`CMLA_CTL_PRELOAD_BIT];

	// Macrocells
	genvar gi;
	generate
		for (gi = 0; gi < `CMLA_CELLS; gi++) begin : g_cell
			cmla_pkg::cmla_cell_s res;
			localparam int ADJ = (gi < `CMLA_CELLS / 2) ? gi - 1 : gi + 1;
			localparam int ADJ_IDX = (ADJ < 0) ? 0 : ((ADJ >= `CMLA_CELLS) ? `CMLA_CELLS - 1 : ADJ);
			cmla_cell #(
				.IDX(gi)
			) u_cell (
				.permit(cfg_q.global_register_permit_bit),
				.emul(cfg_q.global_emulation_select_bit),
				.sel(cfg_q.cell_mode_select_bit[gi]),
				.pol(cfg_q.cell_polarity_bit[gi]),
				.terms(product_terms[gi*`CMLA_TERMS +: `CMLA_TERMS]),
				.reg_q(cell_q[gi]),
				.own_pin(io_in[gi]),
				.adj_pin(io_in[ADJ_IDX]),
				.clk_pin(clk_pin),
				.oe_pin_n(oe_pin_n),
				.res(res)
			);
			assign unsup[gi] = res.unsup;
			assign reg_used[gi] = res.reg_used;
			assign drive_val[gi] = res.drive_val;
			assign drive_en[gi] = res.drive_en;
			assign fb[gi] = res.feedback;
			assign reg_d[gi] = res.reg_d;
		end
	endgenerate

	// Configuration is static between writes; erase returns it to blank
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cfg_q.global_register_permit_bit <= `CMLA_RST_PERMIT;
			cfg_q.global_emulation_select_bit <= `CMLA_RST_EMUL;
			cfg_q.cell_mode_select_bit <= `CMLA_RST_BYTE;
			cfg_q.cell_polarity_bit <= `CMLA_RST_BYTE;
		end else if (do_erase) begin
			cfg_q.global_register_permit_bit <= `CMLA_RST_PERMIT; // see [RL22]
			cfg_q.global_emulation_select_bit <= `CMLA_RST_EMUL;
			cfg_q.cell_mode_select_bit <= `CMLA_RST_BYTE;
			cfg_q.cell_polarity_bit <= `CMLA_RST_BYTE;
		end else begin
			if (wr_global) begin
				cfg_q.global_register_permit_bit <= wr_data[`CMLA_GLB_PERMIT_BIT]; // see [RL6]
				cfg_q.global_emulation_select_bit <= wr_data[`CMLA_GLB_EMUL_BIT];
			end
			if (wr_select)
				cfg_q.cell_mode_select_bit <= wr_data[`CMLA_CELLS-1:0];
			if (wr_polarity)
				cfg_q.cell_polarity_bit <= wr_data[`CMLA_CELLS-1:0]; // see [RL8]
		end
	end

	// Security bit: set by software, cleared only together with the array
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			secure_q <= 1'b0;
		else if (do_erase)
			secure_q <= 1'b0; // see [RL14]
		else if (wr_control && wr_data[`CMLA_CTL_SECURE_BIT])
			secure_q <= 1'b1;
	end

	// Signature word, also blanked by erase
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			signature_q <= `CMLA_RST_SIG;
		else if (do_erase)
			signature_q <= `CMLA_RST_SIG; // see [RL17]
		else begin
			if (wr_sig_lo)
				signature_q[31:0] <= wr_data; // see [RL15]
			if (wr_sig_hi)
				signature_q[63:32] <= wr_data; // see [RL15]
		end
	end

	// Shared clock pin edge
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			clk_pin_q <= 1'b0;
		else
			clk_pin_q <= clk_pin;
	end
	// A non-registered device never clocks its cells
	assign clk_rise = clk_pin && !clk_pin_q && !cfg_q.global_register_permit_bit; // see [RL6]

	// Cell flip-flops; preload takes the pin level, stored inverted like normal data
	always_comb begin
		cell_d = cell_q;
		for (int i = 0; i < `CMLA_CELLS; i++) begin
			if (reg_used[i]) begin
				if (do_preload)
					cell_d[i] = ~io_in[i]; // see [RL12]
				else if (clk_rise)
					cell_d[i] = reg_d[i]; // see [RL18]
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			cell_q <= '0; // see [RL9]
		else
			cell_q <= cell_d;
	end

	// Pin and feedback outputs, each one register behind the cell logic
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			io_out_q <= '0;
			io_oe_n_q <= '1;
			feedback_q <= '0;
		end else begin
			io_out_q <= drive_val; // see [RL11]
			io_oe_n_q <= ~drive_en;
			feedback_q <= fb;
		end
	end

	// Read mux; configuration reads as zero once secured
	always_comb begin
		rd_data_d = `CMLA_RST_WORD;
		if (rd_en) begin
			unique case (addr)
				`CMLA_OFS_GLOBAL: begin
					if (!secure_q) begin // see [RL13]
						rd_data_d[`CMLA_GLB_PERMIT_BIT] = cfg_q.global_register_permit_bit;
						rd_data_d[`CMLA_GLB_EMUL_BIT] = cfg_q.global_emulation_select_bit;
					end
				end
				`CMLA_OFS_SELECT: begin
					if (!secure_q)
						rd_data_d[`CMLA_CELLS-1:0] = cfg_q.cell_mode_select_bit; // see [RL13]
				end
				`CMLA_OFS_POLARITY: begin
					if (!secure_q)
						rd_data_d[`CMLA_CELLS-1:0] = cfg_q.cell_polarity_bit; // see [RL13]
				end
				`CMLA_OFS_STATUS: begin
					rd_data_d[`CMLA_CELLS-1:0] = cell_q;
					rd_data_d[`CMLA_STS_SECURE_BIT] = secure_q;
					rd_data_d[`CMLA_STS_UNSUP_LSB +: `CMLA_CELLS] = unsup; // see [RL22]
				end
				`CMLA_OFS_SIG_LO: begin
					rd_data_d = signature_q[31:0]; // see [RL16]
				end
				`CMLA_OFS_SIG_HI: begin
					rd_data_d = signature_q[63:32]; // see [RL16]
				end
				default: begin
					rd_data_d = `CMLA_RST_WORD;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			rd_data_q <= `CMLA_RST_WORD;
		else
			rd_data_q <= rd_data_d;
	end

	assign rd_data = rd_data_q;
	assign io_out = io_out_q;
	assign io_oe_n = io_oe_n_q;
	assign array_feedback = feedback_q;

endmodule

// File: tb/cmla_board.sv
/* Board model: resolves each cell pin from the device drive and the board.
   Assumes io_oe_n low means the device drives the pin. */
`timescale 1ns/1ps
module cmla_board (
	// Device side
	input wire logic [7:0] io_out,
	input wire logic [7:0] io_oe_n,
	// Board side
	input wire logic [7:0] drive,
	output logic [7:0] io_in
);
	// Released pins take the board level, so preload sees any state
	assign io_in = (io_out & ~io_oe_n) | (drive & io_oe_n);
endmodule

// File: tb/cmla_top_monitor.sv
/* Checker for cmla_top; mirrors the mode bits from register writes.
   Assumes it is bound into cmla_top. */
`timescale 1ns/1ps
`include "cmla_map.svh"
module cmla_top_monitor (
	// Clock
	input wire logic clk,
	input wire logic reset_n,
	// Register port
	input wire logic [`CMLA_ADDR_W-1:0] addr,
	input wire logic [`CMLA_DATA_W-1:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [`CMLA_DATA_W-1:0] rd_data,
	// Pins
	input wire logic clk_pin,
	input wire logic oe_pin_n,
	input wire logic [`CMLA_CELLS-1:0] io_in,
	input wire logic [`CMLA_CELLS-1:0] io_oe_n,
	input wire logic [`CMLA_CELLS-1:0] io_out,
	input wire logic [`CMLA_CELLS*`CMLA_TERMS-1:0] product_terms,
	input wire logic [`CMLA_CELLS-1:0] array_feedback
);
	logic [1:0] g_q;
	logic [7:0] s_q, p_q, sm, t7, cout, ded, cio;
	logic sec_q;
	logic [31:0] sig_q;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			g_q <= 2'h0;
			s_q <= 8'h00;
			p_q <= 8'h00;
			sec_q <= 1'b0;
			sig_q <= 32'h0;
		end else if (wr_en) begin
			case (addr)
			`CMLA_OFS_GLOBAL: g_q <= wr_data[1:0];
			`CMLA_OFS_SELECT: s_q <= wr_data[7:0];
			`CMLA_OFS_POLARITY: p_q <= wr_data[7:0];
			`CMLA_OFS_SIG_LO: sig_q <= wr_data;
			`CMLA_OFS_CONTROL: begin
				sec_q <= (sec_q | wr_data[1]) & ~wr_data[2];
				if (wr_data[2]) begin
					g_q <= 2'h0;
					s_q <= 8'h00;
					p_q <= 8'h00;
					sig_q <= 32'h0;
				end
			end
			default: ;
			endcase
		end
	end
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			sm[i] = |product_terms[8*i+:8];
			t7[i] = product_terms[8*i+7];
		end
	end
	assign cout = (g_q == 2'h1) ? ~s_q : 8'h00;
	assign ded = (g_q == 2'h1) ? s_q : 8'h00;
	assign cio = g_q[1] ? s_q : 8'h00;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	a_input_released: assert property (($past(ded) & ~io_oe_n) == 8'h00)
		else $error("input cell drives its pin");
	a_comb_driven: assert property (($past(cout) & io_oe_n) == 8'h00)
		else $error("combinational output released");
	a_out_polarity: assert property
		(($past(cout) & (io_out ^ $past(p_q) ^ $past(sm) ^ 8'hff)) == 8'h00)
		else $error("output polarity wrong");
	a_io_enable: assert property
		(($past(cio) & (io_oe_n ^ $past(t7) ^ 8'hff)) == 8'h00)
		else $error("enable term not obeyed");
	a_io_own_pin: assert property
		(($past(cio) & (array_feedback ^ $past(io_in))) == 8'h00)
		else $error("I/O cell feedback not own pin");
	a_no_fb_pins: assert property
		(($past(cout) & array_feedback & 8'h18) == 8'h00)
		else $error("feedback on pins 15 or 16");
	a_enable_pin_in: assert property
		($past(ded[0]) |-> array_feedback[0] == $past(oe_pin_n))
		else $error("first end cell input wrong");
	a_clock_pin_in: assert property
		($past(g_q == 2'h1) |-> array_feedback[7] == $past(clk_pin))
		else $error("clock pin not on last end cell");
	a_sig_read: assert property
		(rd_en && addr == `CMLA_OFS_SIG_LO |=> rd_data == $past(sig_q))
		else $error("signature read wrong");
	a_secure_hide: assert property
		(rd_en && sec_q && addr == `CMLA_OFS_GLOBAL |=> rd_data == 32'h0)
		else $error("secured config readable");
	cover property (rd_en && addr == `CMLA_OFS_SIG_LO);
	cover property (ded[0]);
	cover property (sec_q && rd_en);
endmodule
bind cmla_top cmla_top_monitor u_cmla_top_monitor (.clk(clk), .reset_n(reset_n), .addr(addr),
	.wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .clk_pin(clk_pin),
	.oe_pin_n(oe_pin_n), .io_in(io_in), .io_oe_n(io_oe_n), .io_out(io_out),
	.product_terms(product_terms), .array_feedback(array_feedback));

// File: tb/test_config_macrocell_logic_array.sv
/* Self-checking bench for cmla_top: modes, preload, security, signature.
   Assumes cmla_board resolves the cell pins. */
`timescale 1ns/1ps
`include "cmla_map.svh"
module test_config_macrocell_logic_array;
	logic clk, reset_n, wr_en, rd_en, clk_pin, oe_pin_n;
	logic [7:0] addr, io_in, io_out, io_oe_n, fb, drive, pol, e;
	logic [31:0] wr_data, rd_data, r;
	logic [63:0] terms;
	int n_errors, samples_checked;
	cmla_top u_cmla_top (.clk(clk), .reset_n(reset_n), .addr(addr), .wr_data(wr_data),
		.wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .clk_pin(clk_pin),
		.oe_pin_n(oe_pin_n), .io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n),
		.product_terms(terms), .array_feedback(fb));
	cmla_board u_cmla_board (.io_out(io_out), .io_oe_n(io_oe_n), .drive(drive), .io_in(io_in));
	function automatic logic [7:0] sop(logic [63:0] t, logic [7:0] p);
		for (int i = 0; i < 8; i++)
			sop[i] = ~(p[i] ^ (|t[8*i+:8]));
	endfunction
	function automatic logic [7:0] sop7(logic [63:0] t, logic [7:0] p);
		for (int i = 0; i < 8; i++)
			sop7[i] = ~(p[i] ^ (|t[8*i+:7]));
	endfunction
	function automatic logic [7:0] adj(logic [7:0] p, logic c, logic o);
		adj = {c, p[7:5], p[2:0], o};
	endfunction
	task automatic chk(logic [31:0] s, logic [31:0] x);
		samples_checked++;
		if (s !== x) begin
			n_errors++;
			$display("Error at %0t: seen %h expected %h", $time, s, x);
		end
	endtask
	task automatic wt(int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge clk);
		wr_en <= 1'b1;
		addr <= a;
		wr_data <= d;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a, logic [31:0] x);
		@(posedge clk);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_en <= 1'b0;
		@(negedge clk);
		chk(rd_data, x);
	endtask
	task automatic report_and_stop();
		if (n_errors == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		report_and_stop();
	end
	initial begin
		{reset_n, wr_en, rd_en, clk_pin, oe_pin_n} = 5'h01;
		{addr, drive, wr_data, terms} = '0;
		r = $urandom(32324);
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		rd(8'h40, 32'h0);
		rd(`CMLA_OFS_STATUS, 32'h00ff0000);
		chk(io_oe_n, 8'hff);
		wr(`CMLA_OFS_POLARITY, 32'hff);
		wr(`CMLA_OFS_GLOBAL, 32'h2);
		@(posedge clk);
		oe_pin_n <= 1'b0;
		wt(2);
		chk(io_out, 8'hff);
		chk(io_oe_n, 8'h00);
		repeat (8) begin
			@(posedge clk);
			terms <= {$urandom, $urandom};
			clk_pin <= 1'b1;
			wt(2);
			e = sop(terms, 8'hff);
			chk(io_out, e);
			chk(fb, e);
			@(posedge clk);
			terms <= {$urandom, $urandom};
			clk_pin <= 1'b0;
			wt(2);
			chk(io_out, e);
		end
		// Released pins let the board supply the preload pattern
		@(posedge clk);
		oe_pin_n <= 1'b1;
		drive <= 8'($urandom);
		wt(2);
		wr(`CMLA_OFS_CONTROL, 32'h1);
		@(posedge clk);
		oe_pin_n <= 1'b0;
		wt(2);
		chk(io_out, drive);
		wr(`CMLA_OFS_GLOBAL, 32'h1);
		wr(`CMLA_OFS_SELECT, 32'h0);
		repeat (16) begin
			pol = 8'($urandom);
			wr(`CMLA_OFS_POLARITY, {24'h0, pol});
			terms <= {$urandom, $urandom};
			clk_pin <= ~clk_pin;
			wt(2);
			e = sop(terms, pol);
			chk(io_out, e);
			chk(fb, {clk_pin, e[6:5], 2'b00, e[2:1], oe_pin_n});
		end
		// Clock pin toggled above; preloaded cell state must be untouched
		rd(`CMLA_OFS_STATUS, {24'h000000, ~drive});
		wr(`CMLA_OFS_SELECT, 32'hff);
		repeat (8) begin
			@(posedge clk);
			drive <= 8'($urandom);
			clk_pin <= 1'($urandom);
			oe_pin_n <= 1'($urandom);
			wt(2);
			chk(io_oe_n, 8'hff);
			chk(fb, adj(drive, clk_pin, oe_pin_n));
		end
		for (int g = 2; g < 4; g++) begin
			wr(`CMLA_OFS_GLOBAL, 32'(g));
			repeat (8) begin
				@(posedge clk);
				terms <= {$urandom, $urandom};
				wt(2);
				for (int i = 0; i < 8; i++)
					e[i] = ~terms[8*i+7];
				chk(io_oe_n, e);
				chk(io_out, sop7(terms, pol));
			end
		end
		r = $urandom;
		wr(`CMLA_OFS_SIG_LO, r);
		wr(`CMLA_OFS_SIG_HI, ~r);
		rd(`CMLA_OFS_GLOBAL, 32'h3);
		wr(`CMLA_OFS_CONTROL, 32'h2);
		rd(`CMLA_OFS_GLOBAL, 32'h0);
		rd(`CMLA_OFS_SIG_LO, r);
		rd(`CMLA_OFS_SIG_HI, ~r);
		wr(`CMLA_OFS_CONTROL, 32'h0);
		rd(`CMLA_OFS_SELECT, 32'h0);
		// This programming pass starts with an erase of the whole array
		wr(`CMLA_OFS_CONTROL, 32'h6);
		wr(`CMLA_OFS_SELECT, 32'h5a);
		rd(`CMLA_OFS_SELECT, 32'h5a);
		rd(`CMLA_OFS_SIG_HI, 32'h0);
		report_and_stop();
	end
endmodule
